// ---- src/lpf_fault_ctrl.sv ----
// Fault supervision of a single-wire bus transmitter with Wishbone registers.
// Assumes transmit data and overcurrent sense are synchronous to SYS_CLK.
//
// Operation
// - Both fault flags merge into one interrupt
// - Overcurrent in mask window only limits current
// - Overcurrent outside window disables, sets flag
// - Re-enable needs no overcurrent, quiet bit time
// - Write one clears flag, transmitter returns
// - Failed re-enable keeps off, flag again
// - Failed re-enable flags after one-two RC periods
// - Both fault types switch transmitter off
// - Timeout ends on a clear while transmit data recessive
`timescale 1ns/100ps
module lpf_fault_ctrl #(
    parameter int unsigned MASK_CYCLES = lpf_pkg::OCLIM_CYCLES,
    parameter int unsigned RC_DIV = lpf_pkg::IRC_CYCLES
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Transmit path
    input wire logic PHY_TRANSMIT_DATA,
    input wire logic OVERCURRENT,
    output logic TX_DRIVE_EN,
    output logic CURRENT_LIMIT,
    // Interrupt
    output logic LINE_PHY_IRQ
);
    import lpf_pkg::*;

    typedef struct packed {
        logic [2:0] phy_control_reg;
        logic [1:0] phy_irq_enable_reg;
        logic [1:0] flags;
        logic [15:0] bit_time;
        logic [23:0] dt_limit;
        lpf_oc_state_t oc_state;
        logic [1:0] tick_cnt;
        logic dt_block;
        logic txd_prev;
        logic [15:0] win_cnt;
        logic [15:0] quiet_cnt;
        logic [23:0] dom_cnt;
        logic [31:0] rdata;
        logic ack;
        logic tx_en;
        logic limit;
        logic irq;
    } lpf_st_t;

    lpf_st_t st_ff;
    lpf_st_t nxt_st;
    logic rc_tick;

    lpf_rc_tick #(
        .DIV(RC_DIV)
    ) u_rc_tick (
        .clk(SYS_CLK),
        .rst_n(RSTN),
        .tick(rc_tick)
    );

    // Byte-lane merge for a register write
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    logic req;
    logic wr;
    logic [31:0] wmask;
    logic phy_on;
    logic normal_mode;
    logic dominant;
    logic quiet_ok;
    logic oc_clear;
    logic dt_clear;
    logic [1:0] flag_set;
    logic tx_allowed;
    logic recheck_fail;
    logic [31:0] merged;

    always_comb begin
        nxt_st = st_ff;
        req = WB_CYC_I && WB_STB_I && !st_ff.ack;
        wr = req && WB_WE_I;
        wmask = lane_merge(32'h00000000, WB_DAT_I, WB_SEL_I);
        merged = 32'h00000000;
        phy_on = st_ff.phy_control_reg[CTRL_ENABLE_BIT];
        normal_mode = phy_on && !st_ff.phy_control_reg[CTRL_RX_ONLY_BIT];
        dominant = !PHY_TRANSMIT_DATA;
        quiet_ok = st_ff.quiet_cnt >= st_ff.bit_time;
        flag_set = 2'h0;
        recheck_fail = 1'b0;

        // Only ones clear; zeros leave the flag alone
        oc_clear = wr && (WB_ADR_I == ADDR_FLAGS) && wmask[OC_BIT];
        dt_clear = wr && (WB_ADR_I == ADDR_FLAGS) && wmask[DT_BIT];

        // Bus side: ack one cycle after the request, dropped the next cycle
        nxt_st.ack = req;
        nxt_st.rdata = 32'h00000000;
        if (req && !WB_WE_I) begin
            case (WB_ADR_I)
                ADDR_CTRL: nxt_st.rdata = 32'(st_ff.phy_control_reg);
                ADDR_IRQ_EN: nxt_st.rdata = 32'(st_ff.phy_irq_enable_reg);
                ADDR_FLAGS: nxt_st.rdata = 32'(st_ff.flags);
                ADDR_STATE: begin
                    nxt_st.rdata[ST_TX_ON_BIT] = st_ff.tx_en;
                    nxt_st.rdata[ST_OC_BLOCK_BIT] = (st_ff.oc_state != OC_RUN);
                    nxt_st.rdata[ST_DT_BLOCK_BIT] = st_ff.dt_block;
                    nxt_st.rdata[ST_LIMIT_BIT] = st_ff.limit;
                    nxt_st.rdata[ST_TXD_BIT] = PHY_TRANSMIT_DATA;
                end
                ADDR_BIT_TIME: nxt_st.rdata = 32'(st_ff.bit_time);
                ADDR_DT_LIMIT: nxt_st.rdata = 32'(st_ff.dt_limit);
                default: nxt_st.rdata = 32'h00000000;
            endcase
        end
        if (wr) begin
            case (WB_ADR_I)
                ADDR_CTRL: begin
                    merged = lane_merge(32'(st_ff.phy_control_reg), WB_DAT_I, WB_SEL_I);
                    nxt_st.phy_control_reg = merged[2:0];
                end
                ADDR_IRQ_EN: begin
                    merged = lane_merge(32'(st_ff.phy_irq_enable_reg), WB_DAT_I, WB_SEL_I);
                    nxt_st.phy_irq_enable_reg = merged[1:0];
                end
                ADDR_BIT_TIME: begin
                    merged = lane_merge(32'(st_ff.bit_time), WB_DAT_I, WB_SEL_I);
                    nxt_st.bit_time = merged[15:0];
                end
                ADDR_DT_LIMIT: begin
                    merged = lane_merge(32'(st_ff.dt_limit), WB_DAT_I, WB_SEL_I);
                    nxt_st.dt_limit = merged[23:0];
                end
                default: begin
                end
            endcase
        end

        // Mask window restarts on every falling edge of transmit data
        nxt_st.txd_prev = PHY_TRANSMIT_DATA;
        if (st_ff.txd_prev && !PHY_TRANSMIT_DATA) begin
            nxt_st.win_cnt = 16'(MASK_CYCLES);
        end else if (st_ff.win_cnt != 16'h0000) begin
            nxt_st.win_cnt = st_ff.win_cnt - 16'h0001;
        end

        // Quiet time: recessive, shut down or receive-only, saturating
        if (!dominant || !normal_mode) begin
            if (st_ff.quiet_cnt != 16'hFFFF) begin
                nxt_st.quiet_cnt = st_ff.quiet_cnt + 16'h0001;
            end
        end else begin
            nxt_st.quiet_cnt = 16'h0000;
        end

        tx_allowed = normal_mode && (st_ff.oc_state == OC_RUN) && !st_ff.dt_block;

        // Inside the window the driver only limits, no flag
        nxt_st.limit = tx_allowed && OVERCURRENT && (st_ff.win_cnt != 16'h0000);

        // Overcurrent supervision
        nxt_st.tick_cnt = 2'h0;
        case (st_ff.oc_state)
            OC_RUN: begin
                if (tx_allowed && OVERCURRENT && (st_ff.win_cnt == 16'h0000)) begin
                    nxt_st.oc_state = OC_OFF;
                    flag_set[OC_BIT] = 1'b1;
                end
            end
            OC_OFF: begin
                // Clear is only honoured while the flag is really set
                if (oc_clear && st_ff.flags[OC_BIT]) begin
                    nxt_st.oc_state = OC_RECHK;
                end
            end
            OC_RECHK: begin
                // Two RC ticks give one to two RC periods of settling
                nxt_st.tick_cnt = st_ff.tick_cnt;
                if (rc_tick) begin
                    nxt_st.tick_cnt = st_ff.tick_cnt + 2'h1;
                    if (st_ff.tick_cnt == 2'h1) begin
                        nxt_st.oc_state = OC_EVAL;
                    end
                end
            end
            OC_EVAL: begin
                recheck_fail = OVERCURRENT || !quiet_ok || (dominant && normal_mode);
                if (recheck_fail) begin
                    nxt_st.oc_state = OC_OFF;
                    flag_set[OC_BIT] = 1'b1;
                end else begin
                    nxt_st.oc_state = OC_RUN;
                end
            end
            default: nxt_st.oc_state = OC_OFF;
        endcase

        // Dominant timeout supervision
        if (dominant && normal_mode && !st_ff.dt_block) begin
            if (st_ff.dom_cnt != 24'hFFFFFF) begin
                nxt_st.dom_cnt = st_ff.dom_cnt + 24'h000001;
            end
        end else begin
            nxt_st.dom_cnt = 24'h000000;
        end
        if (!st_ff.phy_control_reg[CTRL_DT_DISABLE_BIT] && !st_ff.dt_block
            && (st_ff.dom_cnt >= st_ff.dt_limit) && dominant && normal_mode) begin
            nxt_st.dt_block = 1'b1;
            flag_set[DT_BIT] = 1'b1;
        end else if (st_ff.dt_block && dt_clear && st_ff.flags[DT_BIT]) begin
            if (!dominant) begin
                nxt_st.dt_block = 1'b0;
            end else begin
                flag_set[DT_BIT] = 1'b1;
            end
        end

        // Sticky flags: a new fault beats a clear in the same cycle
        for (int i = 0; i < 2; i++) begin
            if (flag_set[i]) begin
                nxt_st.flags[i] = 1'b1;
            end else if (wr && (WB_ADR_I == ADDR_FLAGS) && wmask[i]) begin
                nxt_st.flags[i] = 1'b0;
            end
        end

        nxt_st.tx_en = normal_mode && (nxt_st.oc_state == OC_RUN) && !nxt_st.dt_block;
        nxt_st.irq = |(nxt_st.flags & nxt_st.phy_irq_enable_reg);
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_ff.phy_control_reg <= CTRL_RESET;
            st_ff.phy_irq_enable_reg <= IRQ_EN_RESET;
            st_ff.flags <= 2'h0;
            st_ff.bit_time <= BIT_TIME_RESET;
            st_ff.dt_limit <= DT_LIMIT_RESET;
            st_ff.oc_state <= OC_RUN;
            st_ff.tick_cnt <= 2'h0;
            st_ff.dt_block <= 1'b0;
            st_ff.txd_prev <= 1'b1;
            st_ff.win_cnt <= 16'h0000;
            st_ff.quiet_cnt <= 16'h0000;
            st_ff.dom_cnt <= 24'h000000;
            st_ff.rdata <= 32'h00000000;
            st_ff.ack <= 1'b0;
            st_ff.tx_en <= 1'b0;
            st_ff.limit <= 1'b0;
            st_ff.irq <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign WB_DAT_O = st_ff.rdata;
    assign WB_ACK_O = st_ff.ack;
    assign TX_DRIVE_EN = st_ff.tx_en;
    assign CURRENT_LIMIT = st_ff.limit;
    assign LINE_PHY_IRQ = st_ff.irq;
endmodule

// ---- src/lpf_pkg.sv ----
// Shared constants for the line transmitter fault supervisor.
// Assumes a 100 MHz system clock and 32-bit classic Wishbone registers.
package lpf_pkg;
    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned IRC_PERIOD_NS = 1000;
    localparam int unsigned IRC_CYCLES = IRC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned OCLIM_NS = 4000;
    localparam int unsigned OCLIM_CYCLES = (OCLIM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h04;
    localparam logic [7:0] ADDR_FLAGS = 8'h08;
    localparam logic [7:0] ADDR_STATE = 8'h0C;
    localparam logic [7:0] ADDR_BIT_TIME = 8'h10;
    localparam logic [7:0] ADDR_DT_LIMIT = 8'h14;

    // Control fields
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam int unsigned CTRL_RX_ONLY_BIT = 1;
    localparam int unsigned CTRL_DT_DISABLE_BIT = 2;
    // Flag and enable fields share one layout
    localparam int unsigned DT_BIT = 0;
    localparam int unsigned OC_BIT = 1;
    // State fields
    localparam int unsigned ST_TX_ON_BIT = 0;
    localparam int unsigned ST_OC_BLOCK_BIT = 1;
    localparam int unsigned ST_DT_BLOCK_BIT = 2;
    localparam int unsigned ST_LIMIT_BIT = 3;
    localparam int unsigned ST_TXD_BIT = 4;

    // Reset values
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [1:0] IRQ_EN_RESET = 2'h0;
    localparam logic [15:0] BIT_TIME_RESET = 16'h1458;
    localparam logic [23:0] DT_LIMIT_RESET = 24'h01E848;

    typedef enum logic [1:0] {
        OC_RUN,
        OC_OFF,
        OC_RECHK,
        OC_EVAL
    } lpf_oc_state_t;
endpackage

// ---- src/lpf_rc_tick.sv ----
// Internal RC clock model: one-cycle tick every divider period.
// Assumes the system clock is the only clock; the tick is a clock-enable pulse.
`timescale 1ns/100ps
module lpf_rc_tick #(
    parameter int unsigned DIV = lpf_pkg::IRC_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Tick
    output logic tick
);
    import lpf_pkg::*;

    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } lpf_tick_st_t;

    lpf_tick_st_t st_ff;
    lpf_tick_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (st_ff.cnt == 16'(DIV - 1)) begin
            nxt_st.cnt = 16'h0000;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;
endmodule

// ---- testbench/lpf_line_model.sv ----
// Line and transmit-source model for the fault supervisor bench.
// Assumes the bench commands dominant bits and a short to supply.
`timescale 1ns/100ps
module lpf_line_model (
    // Bench commands
    input wire logic send_dom,
    input wire logic short_bus,
    // Device side
    input wire logic tx_on,
    output logic txd,
    output logic oc
);
    // Source returns recessive as soon as it stops sending
    assign txd = ~send_dom;
    // A short only loads the driver while it pulls dominant
    assign oc = short_bus & tx_on & ~txd;
endmodule

// ---- testbench/lpf_fault_ctrl_chk.sv ----
// Checker of the fault supervisor ports: handshake, mask window, re-enable.
// Assumes it is bound to lpf_fault_ctrl and sees only its ports.
`timescale 1ns/100ps
module lpf_fault_ctrl_chk #(
    parameter int unsigned MASK_CYCLES = lpf_pkg::OCLIM_CYCLES,
    parameter int unsigned RC_DIV = lpf_pkg::IRC_CYCLES
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // Wishbone
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // Transmit path and interrupt
    input wire logic PHY_TRANSMIT_DATA,
    input wire logic OVERCURRENT,
    input wire logic TX_DRIVE_EN,
    input wire logic CURRENT_LIMIT,
    input wire logic LINE_PHY_IRQ
);
    import lpf_pkg::*;
    logic txd_ff;
    logic [15:0] cnt_ff;
    logic fall;
    logic clr_oc;
    assign fall = txd_ff & ~PHY_TRANSMIT_DATA;
    assign clr_oc = WB_ACK_O & WB_CYC_I & WB_STB_I & WB_WE_I & WB_SEL_I[0]
        & WB_DAT_I[OC_BIT] & (WB_ADR_I == ADDR_FLAGS);
    // Cycles since the last falling edge; saturates so idle reads as outside
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            txd_ff <= 1'b1;
            cnt_ff <= 16'hFFFF;
        end else begin
            txd_ff <= PHY_TRANSMIT_DATA;
            if (fall) begin
                cnt_ff <= 16'h0000;
            end else if (cnt_ff != 16'hFFFF) begin
                cnt_ff <= cnt_ff + 16'h0001;
            end
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    property p_ack_pulse;
        WB_ACK_O |=> !WB_ACK_O;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
    property p_ack_time;
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
    endproperty
    a_ack_time: assert property (p_ack_time) else $error("ack late");
    property p_ack_cause;
        $rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_dat_zero;
        !WB_ACK_O |-> WB_DAT_O == 32'h0;
    endproperty
    a_dat_zero: assert property (p_dat_zero) else $error("read data outside ack");
    property p_oc_off;
        OVERCURRENT && TX_DRIVE_EN && !fall && cnt_ff >= MASK_CYCLES + 2 |=> !TX_DRIVE_EN;
    endproperty
    a_oc_off: assert property (p_oc_off) else $error("driver kept on");
    property p_limit_in;
        OVERCURRENT && TX_DRIVE_EN && !fall && cnt_ff >= 1 && cnt_ff + 2 <= MASK_CYCLES
            |=> TX_DRIVE_EN && CURRENT_LIMIT;
    endproperty
    a_limit_in: assert property (p_limit_in) else $error("no limit in window");
    property p_limit_out;
        !fall && cnt_ff >= MASK_CYCLES + 3 |-> !CURRENT_LIMIT;
    endproperty
    a_limit_out: assert property (p_limit_out) else $error("limit after window");
    property p_rechk_hold;
        clr_oc && !TX_DRIVE_EN |=> !TX_DRIVE_EN [*8];
    endproperty
    a_rechk_hold: assert property (p_rechk_hold) else $error("early re-enable");
    c_limit: cover property (CURRENT_LIMIT);
    c_off: cover property ($fell(TX_DRIVE_EN));
    c_irq: cover property ($rose(LINE_PHY_IRQ));
endmodule

bind lpf_fault_ctrl lpf_fault_ctrl_chk #(.MASK_CYCLES(MASK_CYCLES), .RC_DIV(RC_DIV)) i_chk (
    .SYS_CLK(SYS_CLK), .RSTN(RSTN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .PHY_TRANSMIT_DATA(PHY_TRANSMIT_DATA),
    .OVERCURRENT(OVERCURRENT), .TX_DRIVE_EN(TX_DRIVE_EN), .CURRENT_LIMIT(CURRENT_LIMIT),
    .LINE_PHY_IRQ(LINE_PHY_IRQ));

// ---- testbench/tb_lpf_fault_ctrl.sv ----
// Bench for the fault supervisor: registers, window, refail and recovery.
// Assumes lpf_line_model as far side and the bound checker.
`timescale 1ns/100ps
module tb_lpf_fault_ctrl;
    import lpf_pkg::*;
    localparam int unsigned MASK = 8;
    localparam int unsigned RC = 10;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic send_dom = 1'b0;
    logic short_bus = 1'b0;
    logic [31:0] rdat, rd;
    logic ack, txd, oc, tx_en, limit, irq;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;
    logic [31:0] exp_rst [7] = '{32'h0, 32'h0, 32'h0, 32'h10, 32'h1458, 32'h1E848, 32'h0};
    lpf_fault_ctrl #(.MASK_CYCLES(MASK), .RC_DIV(RC)) i_lpf_fault_ctrl (
        .SYS_CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .PHY_TRANSMIT_DATA(txd), .OVERCURRENT(oc), .TX_DRIVE_EN(tx_en),
        .CURRENT_LIMIT(limit), .LINE_PHY_IRQ(irq));
    lpf_line_model i_lpf_line_model (
        .send_dom(send_dom), .short_bus(short_bus), .tx_on(tx_en), .txd(txd), .oc(oc));
    always #5 clk = ~clk;
    task automatic finish_test();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Run should take about 700 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            finish_test();
        end
    end
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        // Last offset is unmapped and must read zero
        for (int i = 0; i < 7; i++) begin
            wb(1'b0, 8'(4 * i), 32'h0);
            chk("reset value", exp_rst[i], rd);
        end
        $display("test registers done");
        wb(1'b1, ADDR_BIT_TIME, 32'd200);
        wb(1'b1, ADDR_DT_LIMIT, 32'd40);
        wb(1'b1, ADDR_IRQ_EN, 32'h3);
        // No wake-up bit exists, so none is enabled for the source
        wb(1'b1, ADDR_CTRL, 32'h1);
        tick(200);
        chk("tx on", 32'h1, 32'(tx_en));
        @(posedge clk);
        send_dom <= 1'b1;
        @(posedge clk);
        short_bus <= 1'b1;
        tick(3);
        chk("limit", 32'h1, 32'(limit));
        chk("tx in window", 32'h1, 32'(tx_en));
        @(posedge clk);
        short_bus <= 1'b0;
        tick(MASK + 2);
        wb(1'b0, ADDR_FLAGS, 32'h0);
        chk("no flag in window", 32'h0, rd);
        short_bus <= 1'b1;
        tick(3);
        chk("tx outside window", 32'h0, 32'(tx_en));
        chk("irq", 32'h1, 32'(irq));
        wb(1'b0, ADDR_FLAGS, 32'h0);
        chk("oc flag", 32'h2, rd);
        short_bus <= 1'b0;
        wb(1'b1, ADDR_FLAGS, 32'h0);
        wb(1'b0, ADDR_FLAGS, 32'h0);
        chk("write zero", 32'h2, rd);
        $display("test window done");
        wb(1'b1, ADDR_IRQ_EN, 32'h2);
        wb(1'b1, ADDR_FLAGS, 32'h2);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (n < 2 || irq !== 1'b1);
        chk("refail early", 32'h1, 32'(n >= RC + 2));
        chk("refail late", 32'h1, 32'(n <= 2 * RC + 3));
        chk("tx stays off", 32'h0, 32'(tx_en));
        tick(30);
        wb(1'b0, ADDR_FLAGS, 32'h0);
        chk("both flags", 32'h3, rd);
        wb(1'b1, ADDR_IRQ_EN, 32'h0);
        tick(2);
        chk("irq masked", 32'h0, 32'(irq));
        wb(1'b1, ADDR_IRQ_EN, 32'h1);
        tick(2);
        chk("irq timeout", 32'h1, 32'(irq));
        $display("test refail done");
        @(posedge clk);
        send_dom <= 1'b0;
        tick(3);
        wb(1'b1, ADDR_FLAGS, 32'h3);
        wb(1'b0, ADDR_FLAGS, 32'h0);
        chk("timeout cleared", 32'h0, rd & 32'h1);
        tick(3 * RC);
        wb(1'b0, ADDR_FLAGS, 32'h0);
        chk("quiet too short", 32'h2, rd);
        tick(250);
        wb(1'b1, ADDR_FLAGS, 32'h2);
        tick(3 * RC);
        chk("tx back", 32'h1, 32'(tx_en));
        wb(1'b0, ADDR_FLAGS, 32'h0);
        chk("flags clear", 32'h0, rd);
        $display("test recovery done");
        finish_test();
    end
endmodule
